// ### rtl/swr_sequencer.sv
// stop/wakeup sequencing, self-clock mode control and reset generator with vector selection
// assumes oscillator, loss, wake and reset-pin inputs are asynchronous; event inputs share clk_i
//
// The placing of the registers and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module swr_sequencer #(
   parameter int CHECK_WINDOW_CYCLES = swr_pkg::CHECK_WINDOW_CYCLES,
   parameter int OSC_GOOD_COUNT = swr_pkg::OSC_GOOD_COUNT
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_we_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic osc_clk_i,
   input wire logic osc_lost_i,
   input wire logic wake_irq_i,
   input wire logic stop_req_i,
   input wire logic power_on_i,
   input wire logic low_voltage_i,
   input wire logic watchdog_timeout_i,
   input wire logic rst_pin_i,
   output logic rst_pin_o,
   output logic rst_pin_oe_o,
   output logic int_reset_o,
   output logic [1:0] vector_o,
   output logic vector_valid_o,
   output logic self_clock_mode_o,
   output logic self_clock_irq_o,
   output logic pll_enable_o,
   output logic voltage_regulator_enable_o,
   output logic system_clock_pll_o,
   output logic clocks_released_o
);
   swr_chk_if chk ();

   logic [2:0] osc_sync_ff;
   logic [1:0] lost_sync_ff;
   logic [1:0] wake_sync_ff;
   logic [1:0] pin_sync_ff;
   logic loss_prev_ff;
   logic [7:0] ctrl_ff;
   logic flag_ff;
   logic scm_ff;
   logic lim_ff;
   logic by_rst_ff;
   logic cm_pend_ff;
   logic wd_pend_ff;
   logic [7:0] rg_cnt_ff;
   logic ack_ff;
   logic [31:0] rdata_ff;
   logic oe_ff;
   logic pin_out_ff;
   logic int_rst_ff;
   logic [1:0] vec_ff;
   logic vec_valid_ff;
   logic scm_out_ff;
   logic irq_out_ff;
   logic pll_en_ff;
   logic voltage_regulator_en_ff;
   logic sys_pll_ff;
   logic released_ff;
   swr_pkg::swr_stop_t st_ff;
   swr_pkg::swr_stop_t nxt_st;
   swr_pkg::swr_rgen_t rg_ff;

   logic clock_loss_detect_enable;
   logic self_clock_enable;
   logic self_clock_irq_enable;
   logic pseudo_stop_select;
   logic pll_sel;
   logic wake_s;
   logic pin_s;
   logic ext_evt;
   logic loss_evt;
   logic scm_enter;
   logic scm_exit;
   logic cm_rst_evt;
   logic fchk_done;
   logic rg_start;
   logic cfg_restore;
   logic leave_stop;
   logic enter_fcheck;
   logic vec_decide;
   logic bus_req;
   logic wr_ctrl;
   logic wr_status;
   logic [31:0] status_word;

   function automatic logic adr_hit(input logic [7:0] adr, input logic [7:0] target);
      adr_hit = (adr[7:2] == target[7:2]);
   endfunction

   // asynchronous pins pass two flops before anything reads them
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         osc_sync_ff <= 3'h0;
         lost_sync_ff <= 2'h0;
         wake_sync_ff <= 2'h0;
         pin_sync_ff <= 2'h3;
      end else begin
         osc_sync_ff <= {osc_sync_ff[1:0], osc_clk_i};
         lost_sync_ff <= {lost_sync_ff[0], osc_lost_i};
         wake_sync_ff <= {wake_sync_ff[0], wake_irq_i};
         pin_sync_ff <= {pin_sync_ff[0], rst_pin_i};
      end
   end

   assign clock_loss_detect_enable = ctrl_ff[swr_pkg::CTRL_CLOCK_LOSS_DETECT_ENABLE];
   assign self_clock_enable = ctrl_ff[swr_pkg::CTRL_SELF_CLOCK_ENABLE];
   assign self_clock_irq_enable = ctrl_ff[swr_pkg::CTRL_SELF_CLOCK_IRQ_ENABLE];
   assign pseudo_stop_select = ctrl_ff[swr_pkg::CTRL_PSEUDO_STOP_SELECT];
   assign pll_sel = ctrl_ff[swr_pkg::CTRL_PLL_SYSTEM_CLOCK_SELECT];
   assign wake_s = wake_sync_ff[1];
   assign pin_s = pin_sync_ff[1];
   assign chk.osc_edge = osc_sync_ff[1] & ~osc_sync_ff[2];
   assign chk.limited = lim_ff;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         loss_prev_ff <= 1'b0;
      end else begin
         loss_prev_ff <= lost_sync_ff[1] & clock_loss_detect_enable & (st_ff != swr_pkg::ST_FSTOP) & (st_ff != swr_pkg::ST_FCHECK);
      end
   end

   // the pin only counts as an outside reset while the generator is idle and not driving it
   assign ext_evt = ~pin_s & (rg_ff == swr_pkg::RG_IDLE);
   assign loss_evt = lost_sync_ff[1] & clock_loss_detect_enable & (st_ff != swr_pkg::ST_FSTOP) & (st_ff != swr_pkg::ST_FCHECK)
                     & ~loss_prev_ff;
   assign fchk_done = (st_ff == swr_pkg::ST_FCHECK) & (chk.good | chk.timeout);
   assign enter_fcheck = (st_ff == swr_pkg::ST_FSTOP) & (wake_s | ext_evt);
   assign scm_enter = (loss_evt & self_clock_enable & ~scm_ff) | ((st_ff == swr_pkg::ST_FCHECK) & chk.timeout & self_clock_enable);
   assign scm_exit = scm_ff & chk.good;
   assign cm_rst_evt = (loss_evt & ~self_clock_enable)
                       | ((st_ff == swr_pkg::ST_FCHECK) & chk.timeout & ~self_clock_enable & ~by_rst_ff);
   assign rg_start = (rg_ff == swr_pkg::RG_IDLE)
                     & ((ext_evt & (st_ff != swr_pkg::ST_FSTOP) & (st_ff != swr_pkg::ST_FCHECK))
                        | power_on_i | low_voltage_i | watchdog_timeout_i | cm_rst_evt
                        | (fchk_done & by_rst_ff));
   // defaults restored on reset in full stop
   assign cfg_restore = rg_start | ((st_ff == swr_pkg::ST_FSTOP) & ext_evt);
   assign leave_stop = (st_ff != swr_pkg::ST_RUN) & (nxt_st == swr_pkg::ST_RUN);
   // a clock-loss reset enters self-clock as well, so it needs its own check run
   assign chk.start = scm_enter | enter_fcheck | (cm_rst_evt & ~scm_ff);

   always_comb begin
      nxt_st = st_ff;
      unique case (st_ff)
         swr_pkg::ST_RUN: begin
            if (stop_req_i && !rg_start) begin
               nxt_st = pseudo_stop_select ? swr_pkg::ST_PSTOP : swr_pkg::ST_FSTOP;
            end
         end
         swr_pkg::ST_PSTOP: begin
            // other wakeup once the clock is good
            if (ext_evt || power_on_i || low_voltage_i || watchdog_timeout_i) begin
               nxt_st = swr_pkg::ST_RUN;
            end else if (loss_evt && (!self_clock_enable || self_clock_irq_enable)) begin
               nxt_st = swr_pkg::ST_RUN;
            end else if (wake_s && !scm_ff) begin
               nxt_st = swr_pkg::ST_RUN;
            end
         end
         swr_pkg::ST_FSTOP: begin
            if (wake_s || ext_evt) begin
               nxt_st = swr_pkg::ST_FCHECK;
            end
         end
         swr_pkg::ST_FCHECK: begin
            if (chk.good || chk.timeout) begin
               nxt_st = swr_pkg::ST_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_ff <= swr_pkg::ST_RUN;
      end else begin
         st_ff <= nxt_st;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         by_rst_ff <= 1'b0;
         lim_ff <= 1'b0;
      end else begin
         if (enter_fcheck) begin
            by_rst_ff <= ext_evt;
            lim_ff <= 1'b1;
         end else if (scm_enter || cm_rst_evt) begin
            lim_ff <= 1'b0;
         end
      end
   end

   // self-clock mode; checks keep running until the oscillator is good again
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         scm_ff <= 1'b0;
      end else if (scm_enter || (cm_rst_evt && !scm_ff)) begin
         scm_ff <= 1'b1;
      end else if (scm_exit) begin
         scm_ff <= 1'b0;
      end
   end

   // writes land on the edge that sees ack, while the master still holds the request
   assign bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
   assign wr_ctrl = wb_cyc_i & wb_stb_i & ack_ff & wb_we_i & wb_sel_i[0] & adr_hit(wb_adr_i, swr_pkg::ADR_CTRL);
   assign wr_status = wb_cyc_i & wb_stb_i & ack_ff & wb_we_i & wb_sel_i[0] & adr_hit(wb_adr_i, swr_pkg::ADR_STATUS);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_ff <= swr_pkg::CTRL_RESET;
      end else if (cfg_restore) begin
         ctrl_ff <= swr_pkg::CTRL_RESET;
         if (cm_rst_evt) begin
            ctrl_ff[swr_pkg::CTRL_CLOCK_LOSS_DETECT_ENABLE] <= 1'b1;
         end
      end else begin
         if (wr_ctrl) begin
            ctrl_ff <= wb_dat_i[7:0];
         end
         if (leave_stop) begin
            ctrl_ff[swr_pkg::CTRL_PLL_SYSTEM_CLOCK_SELECT] <= 1'b0;
         end
      end
   end

   // flag set by self-clock entry and exit, except entry on a clock-loss reset; a set in the clearing cycle wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flag_ff <= 1'b0;
      end else if (scm_enter || scm_exit) begin
         flag_ff <= 1'b1;
      end else if (rg_start || (wr_status && wb_dat_i[swr_pkg::STAT_SELF_CLOCK_IRQ_FLAG])) begin
         flag_ff <= 1'b0;
      end
   end

   assign vec_decide = (rg_ff == swr_pkg::RG_WAIT && rg_cnt_ff == 8'(swr_pkg::RST_WAIT_CYCLES - 1) && pin_s)
                       || (rg_ff == swr_pkg::RG_RISE && pin_s);

   // pendings held until the vector is chosen
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cm_pend_ff <= 1'b0;
         wd_pend_ff <= 1'b0;
      end else begin
         if (cm_rst_evt) begin
            cm_pend_ff <= 1'b1;
         end else if (vec_decide) begin
            cm_pend_ff <= 1'b0;
         end
         if (watchdog_timeout_i) begin
            wd_pend_ff <= 1'b1;
         end else if (vec_decide) begin
            wd_pend_ff <= 1'b0;
         end
      end
   end

   // entry is taken at the first clock edge; without a clock nothing here can advance
   // counting needs the system clock
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rg_ff <= swr_pkg::RG_IDLE;
         rg_cnt_ff <= 8'h00;
      end else begin
         unique case (rg_ff)
            swr_pkg::RG_IDLE: begin
               rg_cnt_ff <= 8'h00;
               if (rg_start) begin
                  rg_ff <= swr_pkg::RG_DRIVE;
               end
            end
            swr_pkg::RG_DRIVE: begin
               if (rg_cnt_ff == 8'(swr_pkg::RST_DRIVE_CYCLES + swr_pkg::RST_SYNC_EXTRA - 1)) begin
                  rg_cnt_ff <= 8'h00;
                  rg_ff <= swr_pkg::RG_WAIT;
               end else begin
                  rg_cnt_ff <= rg_cnt_ff + 8'h01;
               end
            end
            swr_pkg::RG_WAIT: begin
               if (rg_cnt_ff == 8'(swr_pkg::RST_WAIT_CYCLES - 1)) begin
                  rg_cnt_ff <= 8'h00;
                  rg_ff <= pin_s ? swr_pkg::RG_IDLE : swr_pkg::RG_RISE;
               end else begin
                  rg_cnt_ff <= rg_cnt_ff + 8'h01;
               end
            end
            swr_pkg::RG_RISE: begin
               if (pin_s) begin
                  rg_ff <= swr_pkg::RG_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         oe_ff <= 1'b0;
         pin_out_ff <= 1'b0;
         int_rst_ff <= 1'b0;
      end else begin
         pin_out_ff <= 1'b0;
         if (rg_start) begin
            oe_ff <= 1'b1;
         end else if (rg_ff == swr_pkg::RG_DRIVE
                      && rg_cnt_ff == 8'(swr_pkg::RST_DRIVE_CYCLES + swr_pkg::RST_SYNC_EXTRA - 1)) begin
            oe_ff <= 1'b0;
         end
         if (rg_start) begin
            int_rst_ff <= 1'b1;
         end else if (vec_decide) begin
            int_rst_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         vec_ff <= swr_pkg::VEC_NORMAL;
         vec_valid_ff <= 1'b0;
      end else begin
         vec_valid_ff <= vec_decide;
         if (vec_decide) begin
            if (rg_ff == swr_pkg::RG_RISE) begin
               vec_ff <= swr_pkg::VEC_NORMAL;
            end else if (cm_pend_ff) begin
               vec_ff <= swr_pkg::VEC_CLOCK_LOSS;
            end else if (wd_pend_ff) begin
               vec_ff <= swr_pkg::VEC_WATCHDOG;
            end else begin
               vec_ff <= swr_pkg::VEC_NORMAL;
            end
         end
      end
   end

   // pll follows self-clock while stopped; so does the regulator, except in the full-stop check, where it is on
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         scm_out_ff <= 1'b0;
         irq_out_ff <= 1'b0;
         pll_en_ff <= 1'b0;
         voltage_regulator_en_ff <= 1'b1;
         sys_pll_ff <= 1'b0;
         released_ff <= 1'b1;
      end else begin
         scm_out_ff <= scm_ff;
         irq_out_ff <= flag_ff & self_clock_irq_enable;
         pll_en_ff <= scm_ff | ((st_ff == swr_pkg::ST_RUN) & pll_sel);
         voltage_regulator_en_ff <= scm_ff | (st_ff == swr_pkg::ST_RUN) | (st_ff == swr_pkg::ST_FCHECK);
         sys_pll_ff <= scm_ff | ((st_ff == swr_pkg::ST_RUN) & pll_sel);
         released_ff <= (st_ff == swr_pkg::ST_RUN);
      end
   end

   assign status_word = {16'h0000, 6'h00, vec_ff, 2'h0, int_rst_ff, st_ff != swr_pkg::ST_RUN,
                         voltage_regulator_en_ff, pll_en_ff, scm_ff, flag_ff};

   // one wait state; unmapped offsets answer with zero and ignore writes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
      end else begin
         ack_ff <= bus_req;
         if (bus_req) begin
            if (adr_hit(wb_adr_i, swr_pkg::ADR_CTRL)) begin
               rdata_ff <= {24'h00_0000, ctrl_ff};
            end else if (adr_hit(wb_adr_i, swr_pkg::ADR_STATUS)) begin
               rdata_ff <= status_word;
            end else if (adr_hit(wb_adr_i, swr_pkg::ADR_VECTOR)) begin
               rdata_ff <= {30'h0000_0000, vec_ff};
            end else begin
               rdata_ff <= 32'h0000_0000;
            end
         end
      end
   end

   swr_quality_check #(
      .WIN_CYCLES(CHECK_WINDOW_CYCLES),
      .GOOD_COUNT(OSC_GOOD_COUNT)
   ) u_check (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .c(chk.chk)
   );

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdata_ff;
   assign rst_pin_o = pin_out_ff;
   assign rst_pin_oe_o = oe_ff;
   assign int_reset_o = int_rst_ff;
   assign vector_o = vec_ff;
   assign vector_valid_o = vec_valid_ff;
   assign self_clock_mode_o = scm_out_ff;
   assign self_clock_irq_o = irq_out_ff;
   assign pll_enable_o = pll_en_ff;
   assign voltage_regulator_enable_o = voltage_regulator_en_ff;
   assign system_clock_pll_o = sys_pll_ff;
   assign clocks_released_o = released_ff;
endmodule
`default_nettype wire

// ### rtl/swr_pkg.sv
// constants and types shared by the stop/wakeup/reset sequencer and its clock quality checker
// assumes a single 125 MHz system clock and classic wishbone register access
package swr_pkg;
   localparam int CLK_PERIOD_NS = 8;

   // register byte offsets
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_STATUS = 8'h04;
   localparam logic [7:0] ADR_VECTOR = 8'h08;

   // control register fields
   localparam int CTRL_CLOCK_LOSS_DETECT_ENABLE = 0;
   localparam int CTRL_SELF_CLOCK_ENABLE = 1;
   localparam int CTRL_SELF_CLOCK_IRQ_ENABLE = 2;
   localparam int CTRL_PSEUDO_STOP_SELECT = 3;
   localparam int CTRL_PLL_SYSTEM_CLOCK_SELECT = 4;
   localparam logic [7:0] CTRL_RESET = 8'h02;

   // status register fields
   localparam int STAT_SELF_CLOCK_IRQ_FLAG = 0;
   localparam int STAT_SELF_CLOCK_MODE = 1;
   localparam int STAT_PLL_ENABLE = 2;
   localparam int STAT_VOLTAGE_REGULATOR_ENABLE = 3;
   localparam int STAT_STOPPED = 4;
   localparam int STAT_INT_RESET = 5;
   localparam int STAT_VECTOR_LSB = 8;

   // reset generator timing in system clock cycles
   localparam int RST_DRIVE_CYCLES = 128;
   localparam int RST_SYNC_EXTRA = 3;
   localparam int RST_WAIT_CYCLES = 64;
   localparam int RST_TOTAL_CYCLES = 192;

   // clock quality check
   localparam int OSC_GOOD_COUNT = 4096;
   localparam int MAX_CHECK_WINDOWS = 50;
   localparam int CHECK_WINDOW_CYCLES = 16384;

   typedef enum logic [1:0] {VEC_NORMAL, VEC_CLOCK_LOSS, VEC_WATCHDOG} swr_vector_t;
   typedef enum logic [1:0] {ST_RUN, ST_PSTOP, ST_FSTOP, ST_FCHECK} swr_stop_t;
   typedef enum logic [1:0] {RG_IDLE, RG_DRIVE, RG_WAIT, RG_RISE} swr_rgen_t;
endpackage

// ### rtl/swr_chk_if.sv
// handshake between the sequencer and its clock quality checker
// assumes both ends run on the system clock
`timescale 1ns/1ps
`default_nettype none
interface swr_chk_if;
   logic start;
   logic limited;
   logic osc_edge;
   logic good;
   logic timeout;
   logic busy;
   modport ctrl (output start, output limited, output osc_edge, input good, input timeout, input busy);
   modport chk (input start, input limited, input osc_edge, output good, output timeout, output busy);
endinterface
`default_nettype wire

// ### rtl/swr_quality_check.sv
// clock quality checker: counts oscillator edges inside fixed check windows
// assumes osc_edge is already synchronised to the system clock, one pulse per oscillator cycle
`timescale 1ns/1ps
`default_nettype none
module swr_quality_check #(
   parameter int WIN_CYCLES = swr_pkg::CHECK_WINDOW_CYCLES,
   parameter int GOOD_COUNT = swr_pkg::OSC_GOOD_COUNT
) (
   input wire logic clk_i,
   input wire logic rst_i,
   swr_chk_if.chk c
);
   logic busy_ff;
   logic good_ff;
   logic timeout_ff;
   logic [15:0] win_cnt_ff;
   logic [15:0] edge_cnt_ff;
   logic [5:0] wnum_ff;

   // a fresh start always restarts from window one, even while a check is running
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy_ff <= 1'b0;
         good_ff <= 1'b0;
         timeout_ff <= 1'b0;
         win_cnt_ff <= 16'h0000;
         edge_cnt_ff <= 16'h0000;
         wnum_ff <= 6'h00;
      end else begin
         good_ff <= 1'b0;
         timeout_ff <= 1'b0;
         if (c.start) begin
            busy_ff <= 1'b1;
            win_cnt_ff <= 16'h0000;
            edge_cnt_ff <= 16'h0000;
            wnum_ff <= 6'h00;
         end else if (busy_ff) begin
            if (c.osc_edge && edge_cnt_ff == 16'(GOOD_COUNT - 1)) begin
               good_ff <= 1'b1;
               busy_ff <= 1'b0;
            end else if (win_cnt_ff == 16'(WIN_CYCLES - 1)) begin
               win_cnt_ff <= 16'h0000;
               edge_cnt_ff <= 16'h0000;
               if (c.limited && wnum_ff == 6'(swr_pkg::MAX_CHECK_WINDOWS - 1)) begin
                  timeout_ff <= 1'b1;
                  busy_ff <= 1'b0;
               end else if (wnum_ff != 6'h3f) begin
                  wnum_ff <= wnum_ff + 6'h01;
               end
            end else begin
               win_cnt_ff <= win_cnt_ff + 16'h0001;
               if (c.osc_edge) begin
                  edge_cnt_ff <= edge_cnt_ff + 16'h0001;
               end
            end
         end
      end
   end

   assign c.good = good_ff;
   assign c.timeout = timeout_ff;
   assign c.busy = busy_ff;
endmodule
`default_nettype wire

// ### verification/swr_assertions.sv
// port-level checks for the sequencer
// assumes one clock and the synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module swr_assertions (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic power_on_i,
   input wire logic low_voltage_i,
   input wire logic watchdog_timeout_i,
   input wire logic rst_pin_o,
   input wire logic rst_pin_oe_o,
   input wire logic int_reset_o,
   input wire logic [1:0] vector_o,
   input wire logic vector_valid_o,
   input wire logic self_clock_mode_o,
   input wire logic pll_enable_o,
   input wire logic voltage_regulator_enable_o
);
   localparam int DRV = swr_pkg::RST_DRIVE_CYCLES + swr_pkg::RST_SYNC_EXTRA;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [8:0] oe_n_ff;
   logic [8:0] ir_n_ff;
   logic wd_ff;
   always_ff @(posedge clk_i) oe_n_ff <= (rst_i || !rst_pin_oe_o) ? 9'h000 : oe_n_ff + 9'h001;
   always_ff @(posedge clk_i) ir_n_ff <= (rst_i || !int_reset_o) ? 9'h000 : ir_n_ff + 9'h001;
   // cleared at each decision, so a stale pulse cannot excuse a later watchdog vector
   always_ff @(posedge clk_i) wd_ff <= !rst_i && !vector_valid_o && (wd_ff || watchdog_timeout_i);
   chk_ack_time: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
   chk_pin_low: assert property (rst_pin_oe_o |-> !rst_pin_o) else $error("pin driven high");
   chk_seq_start: assert property ((power_on_i || low_voltage_i || watchdog_timeout_i) && !int_reset_o
      |=> rst_pin_oe_o && int_reset_o) else $error("reset not started");
   chk_drive_len: assert property ($fell(rst_pin_oe_o) |-> oe_n_ff == DRV)
      else $error("pin drive length");
   chk_reset_len: assert property ($fell(int_reset_o) |-> ir_n_ff >= DRV + swr_pkg::RST_WAIT_CYCLES)
      else $error("internal reset short");
   chk_valid_fall: assert property (vector_valid_o |-> $fell(int_reset_o)) else $error("valid misplaced");
   chk_valid_once: assert property (vector_valid_o |=> !vector_valid_o) else $error("valid too long");
   chk_wd_vector: assert property (vector_valid_o && !wd_ff |-> vector_o != swr_pkg::VEC_WATCHDOG)
      else $error("watchdog vector unexpected");
   chk_scm_pll: assert property (self_clock_mode_o |-> pll_enable_o && voltage_regulator_enable_o) else $error("scm no pll");
   cover property (vector_valid_o && vector_o == swr_pkg::VEC_WATCHDOG);
   cover property ($fell(self_clock_mode_o));
   cover property ($fell(int_reset_o) && ir_n_ff > 9'h100);
endmodule
bind swr_sequencer swr_assertions u_assert (.*);
`default_nettype wire

// ### verification/swr_pin_model.sv
// reset pin circuitry: pull-up, optional external hold low, slow rise
// assumes the device pulls the pin low only while its enable is high
`timescale 1ns/1ps
`default_nettype none
module swr_pin_model (
   input wire logic clk_i,
   input wire logic dev_oe_i,
   input wire logic dev_val_i,
   input wire logic hold_low_i,
   input wire logic [5:0] rise_i,
   output logic pin_o
);
   logic [6:0] up_ff = 7'h7f;
   logic low;
   // an unknown enable before the device's first reset edge must not poison the rise counter
   assign low = (dev_oe_i === 1'b1 && dev_val_i !== 1'b1) || hold_low_i;
   always_ff @(posedge clk_i) up_ff <= low ? 7'h00 : up_ff + {6'h00, up_ff != 7'h7f};
   assign pin_o = !low && up_ff >= {1'b0, rise_i};
endmodule
`default_nettype wire

// ### verification/testbench.sv
// random and corner-case bench for the stop/wakeup/reset sequencer
// assumes short check windows and the pin model on the reset line
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin err_total++; \
   $display("BAD %s exp %h got %h", nm, e, s); end end
`define WAIT(c, lim) begin n = 0; while ((c) !== 1'b1 && n < lim) begin @(posedge clk_i); n++; end \
   if (n >= lim) begin err_total++; complete_run(); end end
module testbench;
   logic clk_i = 1'b0, rst_i = 1'b1, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, osc_run = 1'b1;
   logic osc_clk_i = 1'b0, osc_lost_i = 1'b0, wake_irq_i = 1'b0, stop_req_i = 1'b0, hold_low = 1'b0;
   logic power_on_i = 1'b0, low_voltage_i = 1'b0, watchdog_timeout_i = 1'b0, rst_pin_i;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, q, d;
   logic [3:0] wb_sel_i = 4'hf;
   logic [5:0] rise = 6'h00;
   logic [1:0] vector_o;
   logic wb_ack_o, rst_pin_o, rst_pin_oe_o, int_reset_o, vector_valid_o, self_clock_mode_o;
   logic self_clock_irq_o, pll_enable_o, voltage_regulator_enable_o, system_clock_pll_o, clocks_released_o;
   int err_total = 0, checked = 0, n, ev, seed = 94467;
   swr_sequencer #(.CHECK_WINDOW_CYCLES(64), .OSC_GOOD_COUNT(8)) dut (.*);
   swr_pin_model pin (.clk_i(clk_i), .dev_oe_i(rst_pin_oe_o), .dev_val_i(rst_pin_o), .hold_low_i(hold_low),
      .rise_i(rise), .pin_o(rst_pin_i));
   initial forever #4 clk_i = ~clk_i;
   // oscillator kept below half the system rate and off the clock grid
   initial forever #17.3 osc_clk_i = osc_run & ~osc_clk_i;
   task automatic complete_run();
      if (err_total == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= wd;
      `WAIT(wb_ack_o, 20)
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic stop_now();
      @(posedge clk_i);
      stop_req_i <= 1'b1;
      @(posedge clk_i);
      stop_req_i <= 1'b0;
   endtask
   // an externally held pin always ends in the normal vector
   function automatic logic [1:0] exp_vec(input int e);
      return (e == 2) ? swr_pkg::VEC_WATCHDOG : swr_pkg::VEC_NORMAL;
   endfunction
   task automatic reset_seq(input int e);
      @(posedge clk_i);
      power_on_i <= (e == 0);
      low_voltage_i <= (e == 1);
      watchdog_timeout_i <= (e == 2);
      hold_low <= (e == 3);
      @(posedge clk_i);
      power_on_i <= 1'b0;
      low_voltage_i <= 1'b0;
      watchdog_timeout_i <= 1'b0;
      `WAIT(int_reset_o, 8)
      if (e == 3) begin
         repeat (250) @(posedge clk_i);
         `CHK("held", 1'b1, int_reset_o)
         hold_low <= 1'b0;
      end
      `WAIT(vector_valid_o, 400)
      `CHK("vector", exp_vec(e), vector_o)
      `CHK("int_reset", 1'b0, int_reset_o)
   endtask
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, swr_pkg::ADR_CTRL, 32'h0000_0000);
      `CHK("ctrl_rst", swr_pkg::CTRL_RESET, q[7:0])
      wb(1'b0, 8'h0c, 32'h0000_0000);
      `CHK("unmapped", 32'h0000_0000, q)
      for (int i = 0; i < 6; i++) begin
         d = $random(seed);
         wb(1'b1, swr_pkg::ADR_CTRL, d);
         wb(1'b0, swr_pkg::ADR_CTRL, 32'h0000_0000);
         `CHK("ctrl_rw", d[4:0], q[4:0])
      end
      for (int i = 0; i < 8; i++) begin
         ev = (i < 4) ? i : {$random(seed)} % 4;
         rise <= 6'({$random(seed)} % 48);
         reset_seq(ev);
      end
      wb(1'b1, swr_pkg::ADR_CTRL, 32'h0000_001b);
      stop_now();
      osc_run <= 1'b0;
      osc_lost_i <= 1'b1;
      `WAIT(self_clock_mode_o, 20)
      wb(1'b0, swr_pkg::ADR_STATUS, 32'h0000_0000);
      `CHK("flag_stop", 2'b11, {q[swr_pkg::STAT_STOPPED], q[swr_pkg::STAT_SELF_CLOCK_IRQ_FLAG]})
      osc_run <= 1'b1;
      osc_lost_i <= 1'b0;
      `WAIT(!self_clock_mode_o, 300)
      `CHK("pll_off", 1'b0, pll_enable_o)
      wb(1'b0, swr_pkg::ADR_STATUS, 32'h0000_0000);
      `CHK("still_stop", 1'b1, q[swr_pkg::STAT_STOPPED])
      wake_irq_i <= 1'b1;
      for (int k = 0; k < 20 && q[swr_pkg::STAT_STOPPED] !== 1'b0; k++) wb(1'b0, swr_pkg::ADR_STATUS, 32'h0000_0000);
      `CHK("awake", 1'b0, q[swr_pkg::STAT_STOPPED])
      wake_irq_i <= 1'b0;
      wb(1'b0, swr_pkg::ADR_CTRL, 32'h0000_0000);
      `CHK("pll_sel", 1'b0, q[swr_pkg::CTRL_PLL_SYSTEM_CLOCK_SELECT])
      wb(1'b1, swr_pkg::ADR_CTRL, 32'h0000_0013);
      stop_now();
      `WAIT(!clocks_released_o, 8)
      wake_irq_i <= 1'b1;
      `WAIT(clocks_released_o, 300)
      `CHK("system_clock_pll", 1'b0, system_clock_pll_o)
      wake_irq_i <= 1'b0;
      wb(1'b1, swr_pkg::ADR_STATUS, 32'h0000_0001);
      wb(1'b1, swr_pkg::ADR_CTRL, 32'h0000_000f);
      stop_now();
      osc_run <= 1'b0;
      osc_lost_i <= 1'b1;
      `WAIT(self_clock_irq_o, 20)
      wb(1'b0, swr_pkg::ADR_STATUS, 32'h0000_0000);
      `CHK("scm_wake", 2'b10, {q[swr_pkg::STAT_SELF_CLOCK_MODE], q[swr_pkg::STAT_STOPPED]})
      osc_run <= 1'b1;
      osc_lost_i <= 1'b0;
      `WAIT(!self_clock_mode_o, 300)
      wb(1'b1, swr_pkg::ADR_CTRL, 32'h0000_0001);
      osc_run <= 1'b0;
      osc_lost_i <= 1'b1;
      `WAIT(vector_valid_o, 400)
      `CHK("cm_vector", swr_pkg::VEC_CLOCK_LOSS, vector_o)
      osc_run <= 1'b1;
      osc_lost_i <= 1'b0;
      `WAIT(!self_clock_mode_o, 300)
      stop_now();
      hold_low <= 1'b1;
      `WAIT(int_reset_o, 400)
      hold_low <= 1'b0;
      `WAIT(vector_valid_o, 400)
      `CHK("fstop_vector", swr_pkg::VEC_NORMAL, vector_o)
      wb(1'b0, swr_pkg::ADR_CTRL, 32'h0000_0000);
      `CHK("fstop_cfg", swr_pkg::CTRL_RESET, q[7:0])
      wb(1'b1, swr_pkg::ADR_CTRL, 32'h0000_0003);
      stop_now();
      osc_run <= 1'b0;
      osc_lost_i <= 1'b1;
      repeat (40) @(posedge clk_i);
      `CHK("no_detect", 1'b0, self_clock_mode_o)
      `CHK("gated", 1'b0, clocks_released_o)
      wake_irq_i <= 1'b1;
      `WAIT(self_clock_mode_o, 3500)
      `CHK("scm_after_fail", 1'b1, self_clock_mode_o)
      complete_run();
   end
endmodule
`default_nettype wire
